// ===== core/tsj_pkg.sv
package tsj_pkg;

  // System clock and the nominal rates that the block works against.
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned TRIB_RATE_HZ = 2_048_000;
  localparam int unsigned AGG_RATE_HZ = 8_448_000;
  localparam int unsigned TRIB_TOL_PPM = 50;
  localparam int unsigned SLOT_COUNT = 4;
  localparam int unsigned SLOT_CAPACITY_BITS = 209;

  // Alarm substitution must act within this time; the logic acts in four cycles.
  localparam int unsigned AIS_TIME_US = 600;
  localparam int unsigned AIS_MAX_CYCLES = AIS_TIME_US * (CLK_HZ / 1_000_000);

  // Frame layout: four sets of 212 bits, overhead at the head of the first set.
  localparam logic [1:0] SET_LAST = 2'h3;
  localparam logic [7:0] SET_LAST_OFF = 8'hd3;
  localparam logic [7:0] OVH_LEN = 8'h0c;
  localparam logic [7:0] CTRL_END = 8'h04;
  localparam logic [7:0] OPP_END = 8'h08;

  // Phase step of the smoothing oscillator for the nominal tributary rate.
  localparam logic [31:0] DCO_NOMINAL = 32'((64'(TRIB_RATE_HZ) << 32) / 64'(CLK_HZ));

  // Register byte offsets, control fields and reset value.
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam logic [3:0] REG_JUST = 4'h8;
  localparam logic [3:0] REG_SLIP = 4'hc;
  localparam int unsigned CTRL_SRC_ACT = 0;
  localparam int unsigned CTRL_SNK_ACT = 1;
  localparam logic [1:0] CTRL_RESET = 2'h0;

  // Index of each pin input in the synchroniser vector.
  localparam int unsigned PIN_AGG_CLK = 0;
  localparam int unsigned PIN_AGG_DATA = 1;
  localparam int unsigned PIN_AGG_FS = 2;
  localparam int unsigned PIN_AGG_TSF = 3;
  localparam int unsigned PIN_TRIB_CLK = 4;
  localparam int unsigned PIN_TRIB_DATA = 5;
  localparam int unsigned PIN_TIM_CLK = 6;
  localparam int unsigned PIN_TIM_FS = 7;
  localparam int unsigned PIN_COUNT = 8;

  typedef enum logic [3:0] {
    TSJ_POS_IDLE = 4'b0001,
    TSJ_POS_DATA = 4'b0010,
    TSJ_POS_CTRL = 4'b0100,
    TSJ_POS_OPP = 4'b1000
  } tsj_pos_t;

  typedef struct packed {
    logic [1:0] set;
    logic [7:0] off;
  } tsj_frame_pos_t;

  typedef struct packed {
    logic [7:0] rsvd_hi;
    logic [7:0] snk_fill;
    logic [7:0] src_fill;
    logic [4:0] rsvd_lo;
    logic src_just;
    logic snk_ones;
    logic snk_fail;
  } tsj_status_t;

  // Step the frame position; a frame start forces position zero.
  function automatic tsj_frame_pos_t tsj_advance(tsj_frame_pos_t p, logic fs);
    tsj_frame_pos_t n;
    n = p;
    if (fs) begin
      n = '0;
    end else if (p.off == SET_LAST_OFF) begin
      n.off = 8'h00;
      n.set = p.set + 2'h1;
    end else begin
      n.off = p.off + 8'h01;
    end
    return n;
  endfunction : tsj_advance

  // Bits are interleaved, so the low two offset bits name the owning slot.
  function automatic tsj_pos_t tsj_classify(tsj_frame_pos_t p, logic [1:0] slot);
    tsj_pos_t k;
    k = TSJ_POS_DATA;
    if ((p.set == 2'h0 && p.off < OVH_LEN) || p.off[1:0] != slot) begin
      k = TSJ_POS_IDLE;
    end else if (p.set != 2'h0 && p.off < CTRL_END) begin
      k = TSJ_POS_CTRL;
    end else if (p.set == SET_LAST && p.off < OPP_END) begin
      k = TSJ_POS_OPP;
    end
    return k;
  endfunction : tsj_classify

endpackage : tsj_pkg

// ===== core/tsj_core.sv
`timescale 1ns/1ps
`default_nettype none

module tsj_core #(
  parameter int unsigned SLOT = 1,
  parameter int unsigned SRC_DEPTH = 16,
  parameter int unsigned SNK_DEPTH = 64,
  parameter int unsigned DCO_GAIN_SHIFT = 10
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic aggregate_payload_clock,
  input wire logic aggregate_payload_data,
  input wire logic aggregate_frame_start,
  input wire logic aggregate_trail_signal_fail,
  input wire logic tributary_in_clock,
  input wire logic tributary_in_data,
  input wire logic aggregate_timing_clock,
  input wire logic aggregate_timing_frame_start,
  output logic aggregate_out_data,
  output logic aggregate_out_enable,
  output logic tributary_out_data,
  output logic tributary_out_valid,
  input wire logic tributary_out_ready,
  output logic tributary_out_clock,
  output logic tributary_server_signal_fail,
  output logic all_ones_substitute_action
);

  localparam int unsigned SAW = $clog2(SRC_DEPTH);
  localparam int unsigned KAW = $clog2(SNK_DEPTH);
  localparam logic [1:0] SLOT_IDX = 2'(SLOT - 1);
  localparam logic [SAW:0] SRC_HALF = (SAW + 1)'(SRC_DEPTH / 2);
  localparam logic [SAW:0] SRC_FULL = (SAW + 1)'(SRC_DEPTH);
  localparam logic [KAW:0] SNK_HALF = (KAW + 1)'(SNK_DEPTH / 2);
  localparam logic [KAW:0] SNK_FULL = (KAW + 1)'(SNK_DEPTH);

  typedef struct packed {
    logic [tsj_pkg::PIN_COUNT-1:0] s1;
    logic [tsj_pkg::PIN_COUNT-1:0] s2;
    logic [tsj_pkg::PIN_COUNT-1:0] s3;
    logic [tsj_pkg::PIN_COUNT-1:0] filt;
    logic [1:0] ctrl;
    logic bus_ack;
    logic [31:0] rdata;
    logic [SRC_DEPTH-1:0] src_mem;
    logic [SAW:0] src_wp;
    logic [SAW:0] src_rp;
    tsj_pkg::tsj_frame_pos_t src_pos;
    logic src_just;
    logic src_data;
    logic src_drive;
    logic [15:0] just_count;
    logic [7:0] src_slips;
    logic [SNK_DEPTH-1:0] snk_mem;
    logic [KAW:0] snk_wp;
    logic [KAW:0] snk_rp;
    tsj_pkg::tsj_frame_pos_t snk_pos;
    logic [2:0] cbits;
    logic [31:0] dco;
    logic tick_pend;
    logic [1:0] buf_data;
    logic [1:0] buf_cnt;
    logic subst;
    logic fail;
    logic [7:0] snk_slips;
  } tsj_state_t;

  tsj_state_t st;
  tsj_state_t next_st;
  logic [tsj_pkg::PIN_COUNT-1:0] agree;
  logic [tsj_pkg::PIN_COUNT-1:0] filt_now;
  logic [tsj_pkg::PIN_COUNT-1:0] rise;
  logic src_edge;
  logic snk_edge;
  tsj_pkg::tsj_pos_t src_kind;
  tsj_pkg::tsj_pos_t snk_kind;
  tsj_pkg::tsj_frame_pos_t src_pos_now;
  tsj_pkg::tsj_frame_pos_t snk_pos_now;
  logic just_now;
  logic vote;
  logic subst_now;
  logic [SAW:0] src_fill;
  logic [KAW:0] snk_fill;
  logic signed [31:0] fill_err;
  logic [32:0] dco_sum;
  logic want_read;
  logic pop;
  logic [1:0] cnt_after_pop;
  tsj_pkg::tsj_status_t status;

  // The first stage is read by the second alone; a level counts once stages two and three agree.
  always_comb begin
    agree = ~(st.s2 ^ st.s3);
    filt_now = (st.filt & ~agree) | (st.s3 & agree);
    rise = filt_now & ~st.filt;
    src_edge = rise[tsj_pkg::PIN_TIM_CLK];
    snk_edge = rise[tsj_pkg::PIN_AGG_CLK];
  end

  // Frame positions and their meaning for this slot, on each side.
  always_comb begin
    src_pos_now = tsj_pkg::tsj_advance(st.src_pos, filt_now[tsj_pkg::PIN_TIM_FS]);
    snk_pos_now = tsj_pkg::tsj_advance(st.snk_pos, filt_now[tsj_pkg::PIN_AGG_FS]);
    src_kind = tsj_pkg::tsj_classify(src_pos_now, SLOT_IDX);
    snk_kind = tsj_pkg::tsj_classify(snk_pos_now, SLOT_IDX);
    src_fill = st.src_wp - st.src_rp;
    snk_fill = st.snk_wp - st.snk_rp;
    just_now = (src_pos_now == '0) ? (src_fill < SRC_HALF) : st.src_just;
    vote = (st.cbits[0] & st.cbits[1]) | (st.cbits[0] & st.cbits[2]) | (st.cbits[1] & st.cbits[2]);
    subst_now = !st.ctrl[tsj_pkg::CTRL_SNK_ACT] || filt_now[tsj_pkg::PIN_AGG_TSF];
    fill_err = $signed(32'(snk_fill)) - $signed(32'(SNK_HALF));
    dco_sum = {1'b0, st.dco} + {1'b0, tsj_pkg::DCO_NOMINAL + 32'(fill_err <<< DCO_GAIN_SHIFT)};
    want_read = dco_sum[32] || st.tick_pend;
    pop = (st.buf_cnt != 2'h0) && tributary_out_ready;
    cnt_after_pop = st.buf_cnt - 2'(pop);
  end

  // Status word; only the fail flag is withheld while the sink is inactive, and the ones flag then stands set.
  always_comb begin
    status = '0;
    status.snk_fail = st.fail;
    status.snk_ones = st.subst;
    status.src_just = st.src_just;
    status.src_fill = 8'(src_fill);
    status.snk_fill = 8'(snk_fill);
  end

  // Next state of the whole block.
  always_comb begin
    next_st = st;
    next_st.s1 = {aggregate_timing_frame_start, aggregate_timing_clock, tributary_in_data, tributary_in_clock,
                  aggregate_trail_signal_fail, aggregate_frame_start, aggregate_payload_data,
                  aggregate_payload_clock};
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
    next_st.filt = filt_now;

    // Bus slave: one wait cycle, then the answer stands for the single cycle it is taken.
    if ((avs_read || avs_write) && !st.bus_ack) begin
      next_st.bus_ack = 1'b1;
      unique case (avs_address)
        tsj_pkg::REG_CTRL: next_st.rdata = {30'h0, st.ctrl};
        tsj_pkg::REG_STATUS: next_st.rdata = status;
        tsj_pkg::REG_JUST: next_st.rdata = {16'h0, st.just_count};
        tsj_pkg::REG_SLIP: next_st.rdata = {16'h0, st.src_slips, st.snk_slips};
        default: next_st.rdata = 32'h0;
      endcase
    end else if (st.bus_ack) begin
      next_st.bus_ack = 1'b0;
      if (avs_write && avs_address == tsj_pkg::REG_CTRL && avs_byteenable[0]) begin
        next_st.ctrl = avs_writedata[1:0];
      end
    end

    // Source store write on the tributary's own clock edge; a full store drops the bit.
    if (rise[tsj_pkg::PIN_TRIB_CLK]) begin
      if (src_fill == SRC_FULL) begin
        next_st.src_slips = st.src_slips + 8'h01;
      end else begin
        next_st.src_mem[st.src_wp[SAW-1:0]] = filt_now[tsj_pkg::PIN_TRIB_DATA];
        next_st.src_wp = st.src_wp + (SAW + 1)'(1);
      end
    end

    // Source read by aggregate timing and position; justification decided at frame start.
    if (src_edge) begin
      next_st.src_pos = src_pos_now;
      next_st.src_drive = 1'b0;
      if (src_pos_now == '0) begin
        next_st.src_just = just_now;
        next_st.just_count = st.just_count + 16'(just_now);
      end
      if (st.ctrl[tsj_pkg::CTRL_SRC_ACT] && src_kind != tsj_pkg::TSJ_POS_IDLE) begin
        next_st.src_drive = 1'b1;
        if (src_kind == tsj_pkg::TSJ_POS_CTRL) begin
          next_st.src_data = just_now;
        end else if (src_kind == tsj_pkg::TSJ_POS_OPP && just_now) begin
          next_st.src_data = 1'b0;
        end else if (src_fill != '0) begin
          next_st.src_data = st.src_mem[st.src_rp[SAW-1:0]];
          next_st.src_rp = st.src_rp + (SAW + 1)'(1);
        end else begin
          next_st.src_data = 1'b1;
          next_st.src_slips = st.src_slips + 8'h01;
        end
      end
    end
    // An idle source keeps its store half full so that it starts centred.
    if (!st.ctrl[tsj_pkg::CTRL_SRC_ACT]) begin
      next_st.src_drive = 1'b0;
      next_st.src_rp = next_st.src_wp - SRC_HALF;
    end

    // Sink: collect control bits, vote at the opportunity bit, write slot data.
    if (snk_edge) begin
      next_st.snk_pos = snk_pos_now;
      if (snk_kind == tsj_pkg::TSJ_POS_CTRL) begin
        next_st.cbits = {st.cbits[1:0], filt_now[tsj_pkg::PIN_AGG_DATA]};
      end
      if (snk_kind == tsj_pkg::TSJ_POS_DATA || (snk_kind == tsj_pkg::TSJ_POS_OPP && !vote)) begin
        next_st.snk_mem[st.snk_wp[KAW-1:0]] = filt_now[tsj_pkg::PIN_AGG_DATA];
        next_st.snk_wp = st.snk_wp + (KAW + 1)'(1);
        // On overflow without an oscillator read in the same cycle, the read side jumps back to the centre: one slip, then clean data.
        if (snk_fill == SNK_FULL) begin
          next_st.snk_rp = st.snk_wp + (KAW + 1)'(1) - SNK_HALF;
          next_st.snk_slips = st.snk_slips + 8'h01;
        end
      end
    end

    // Smoothing oscillator: rate pulled by store fill, so reads are evenly spaced.
    next_st.dco = dco_sum[31:0];
    next_st.tick_pend = 1'b0;
    if (pop) begin
      next_st.buf_data = {1'b1, st.buf_data[1]};
    end
    next_st.buf_cnt = cnt_after_pop;
    if (want_read) begin
      // A stalled receiver holds the read back; the store absorbs the delay.
      if (cnt_after_pop == 2'h2) begin
        next_st.tick_pend = 1'b1;
      end else begin
        next_st.buf_cnt = cnt_after_pop + 2'h1;
        if (snk_fill != '0) begin // A full store still holds valid bits; only an empty one reads as ones.
          next_st.buf_data[cnt_after_pop[0]] = st.snk_mem[st.snk_rp[KAW-1:0]];
          next_st.snk_rp = st.snk_rp + (KAW + 1)'(1);
        end else begin
          next_st.buf_data[cnt_after_pop[0]] = 1'b1;
        end
      end
    end

    // All ones replace data, also words already buffered, while inactive or failed.
    next_st.subst = subst_now;
    next_st.fail = st.ctrl[tsj_pkg::CTRL_SNK_ACT] && filt_now[tsj_pkg::PIN_AGG_TSF];
    if (subst_now) begin
      next_st.buf_data = 2'h3;
    end
  end

  // Single state register with synchronous reset to constants.
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      st <= '0;
      st.ctrl <= tsj_pkg::CTRL_RESET;
    end else begin
      st <= next_st;
    end
  end

  // Ports.
  assign avs_readdata = st.rdata;
  assign avs_waitrequest = (avs_read || avs_write) && !st.bus_ack;
  assign aggregate_out_data = st.src_data;
  assign aggregate_out_enable = st.src_drive;
  assign tributary_out_data = st.buf_data[0];
  assign tributary_out_valid = st.buf_cnt != 2'h0;
  assign tributary_out_clock = tributary_out_valid && tributary_out_ready;
  assign tributary_server_signal_fail = st.fail;
  assign all_ones_substitute_action = st.subst;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  sequence src_ctrl_slot;
    src_edge && st.ctrl[tsj_pkg::CTRL_SRC_ACT] && src_kind == tsj_pkg::TSJ_POS_CTRL;
  endsequence

  sequence src_justified_opp;
    src_edge && st.ctrl[tsj_pkg::CTRL_SRC_ACT] && src_kind == tsj_pkg::TSJ_POS_OPP && just_now;
  endsequence

  sequence bus_first_cycle;
    (avs_read || avs_write) && !st.bus_ack;
  endsequence

  control_bit_value_a: assert property (src_ctrl_slot |=> aggregate_out_enable && aggregate_out_data == st.src_just)
    else $error("Control bit does not carry the justification decision.");
  control_bits_agree_a: assert property (src_edge && src_kind == tsj_pkg::TSJ_POS_CTRL && src_pos_now.set != 2'h1
    |-> just_now == st.src_just)
    else $error("Control bits of one frame differ.");
  skip_one_read_a: assert property (src_justified_opp |=> st.src_rp == $past(st.src_rp) && !aggregate_out_data)
    else $error("Justified opportunity bit consumed data.");
  source_release_a: assert property (!st.ctrl[tsj_pkg::CTRL_SRC_ACT] |=> !aggregate_out_enable)
    else $error("Inactive source drives the aggregate.");
  foreign_slot_a: assert property (src_edge && src_kind == tsj_pkg::TSJ_POS_IDLE |=> !aggregate_out_enable)
    else $error("Source drove a position outside its slot.");
  vote_discard_a: assert property (snk_edge && snk_kind == tsj_pkg::TSJ_POS_OPP && vote
    |=> st.snk_wp == $past(st.snk_wp))
    else $error("Stuffing bit written to the sink store.");
  sink_write_a: assert property (snk_edge && snk_kind == tsj_pkg::TSJ_POS_DATA
    |=> st.snk_wp == $past(st.snk_wp) + (KAW + 1)'(1))
    else $error("Slot data bit not written to the sink store.");
  sink_ones_a: assert property (subst_now |=> tributary_out_data ##1 tributary_out_data || !subst_now)
    else $error("All ones not substituted.");
  fail_report_a: assert property (st.ctrl[tsj_pkg::CTRL_SNK_ACT] && filt_now[tsj_pkg::PIN_AGG_TSF]
    |=> tributary_server_signal_fail && all_ones_substitute_action)
    else $error("Trail signal fail not reported.");
  report_quiet_a: assert property (!st.ctrl[tsj_pkg::CTRL_SNK_ACT] |=> !tributary_server_signal_fail)
    else $error("Inactive sink reports status.");
  bus_answer_a: assert property (bus_first_cycle |-> avs_waitrequest ##1 !avs_waitrequest)
    else $error("Bus answer not after one wait cycle.");

endmodule : tsj_core

`default_nettype wire

// ===== tb/tsj_link_model.sv
`timescale 1ns/1ps
`default_nettype none

// Far-end frame source: one aggregate bit every ten clocks, feeding both the sink input and the source timing.
module tsj_link_model #(
  parameter int unsigned SLOT_IDX = 1
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [2:0] ctrl_pattern,
  input wire logic opp_value,
  input wire logic trib_run,
  output logic agg_clock,
  output logic agg_data,
  output logic agg_fs,
  output logic trib_clock,
  output logic strobe,
  output logic [1:0] pos_set,
  output logic [7:0] pos_off
);
  logic [3:0] ph;
  logic own;

  // The position moves one clock before the rising edge, so each bit is settled ahead of it.
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      ph <= 4'h0;
      pos_set <= 2'h0;
      pos_off <= 8'h00;
    end else begin
      ph <= (ph == 4'h9) ? 4'h0 : ph + 4'h1;
      if (ph == 4'h8) begin
        if (pos_off == 8'hd3) begin
          pos_off <= 8'h00;
          pos_set <= pos_set + 2'h1;
        end else begin
          pos_off <= pos_off + 8'h01;
        end
      end
    end
  end

  // Own slot carries zeros, control and opportunity bits follow the scenario, everything else is one.
  assign agg_clock = (ph < 4'h5);
  assign strobe = (ph == 4'h7);
  assign agg_fs = (pos_set == 2'h0) && (pos_off == 8'h00);
  assign own = (pos_off[1:0] == 2'(SLOT_IDX));
  assign trib_clock = trib_run && (ph < 4'h5);
  always_comb begin
    agg_data = !own || (pos_set == 2'h0 && pos_off < 8'h0c);
    if (own && pos_set != 2'h0 && pos_off < 8'h04) agg_data = ctrl_pattern[pos_set - 2'h1];
    if (own && pos_set == 2'h3 && pos_off[7:2] == 6'h01) agg_data = opp_value;
  end
endmodule : tsj_link_model

`default_nettype wire

// ===== tb/tb.sv
`timescale 1ns/1ps
`default_nettype none

module tb;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata, rd;
  logic avs_waitrequest, agg_clock, agg_data, agg_fs, trib_clock, strobe, d0, exp_en;
  logic [1:0] pos_set;
  logic [7:0] pos_off;
  logic tsf = 1'b0;
  logic [2:0] ctrl_pattern = 3'h7;
  logic trib_run = 1'b0;
  logic ready = 1'b1;
  logic out_data, out_en, t_data, t_valid, t_clk, ssf, ais;
  logic [1:0] src_mode = 2'h0;
  logic count_on = 1'b0;
  int fail_count = 0;
  int check_count = 0;
  int ones = 0;
  int bits = 0;
  int cycles = 0;

  initial begin
    forever #5 clk = ~clk;
  end

  tsj_core #(.SLOT(2)) dut (
    .clk(clk), .reset_n(reset_n), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(4'hf), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .aggregate_payload_clock(agg_clock), .aggregate_payload_data(agg_data),
    .aggregate_frame_start(agg_fs), .aggregate_trail_signal_fail(tsf), .tributary_in_clock(trib_clock),
    .tributary_in_data(1'b0), .aggregate_timing_clock(agg_clock), .aggregate_timing_frame_start(agg_fs),
    .aggregate_out_data(out_data), .aggregate_out_enable(out_en), .tributary_out_data(t_data),
    .tributary_out_valid(t_valid), .tributary_out_ready(ready), .tributary_out_clock(t_clk),
    .tributary_server_signal_fail(ssf), .all_ones_substitute_action(ais)
  );

  tsj_link_model #(.SLOT_IDX(1)) link (
    .clk(clk), .reset_n(reset_n), .ctrl_pattern(ctrl_pattern), .opp_value(1'b1), .trib_run(trib_run),
    .agg_clock(agg_clock), .agg_data(agg_data), .agg_fs(agg_fs), .trib_clock(trib_clock), .strobe(strobe),
    .pos_set(pos_set), .pos_off(pos_off)
  );

  task automatic close_out();
    if (fail_count == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : close_out

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  // Requests are held until waitrequest is seen low at an edge; only the timeout ends a hung wait.
  task automatic bus_rd(input logic [3:0] addr, output logic [31:0] data);
    avs_address <= addr;
    avs_read <= 1'b1;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    data = avs_readdata;
    avs_read <= 1'b0;
    // One idle edge keeps a following request from reassigning the strobe in this time step.
    @(posedge clk);
  endtask : bus_rd

  task automatic bus_wr(input logic [3:0] addr, input logic [31:0] data);
    avs_address <= addr;
    avs_writedata <= data;
    avs_write <= 1'b1;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    avs_write <= 1'b0;
    @(posedge clk);
  endtask : bus_wr

  task automatic wait_flag(input logic exp_ssf, input logic exp_ais);
    int n;
    n = 0;
    while ((ssf !== exp_ssf || ais !== exp_ais) && n < 20) begin
      @(posedge clk);
      n++;
    end
    check({ssf, ais}, {exp_ssf, exp_ais});
  endtask : wait_flag

  task automatic frame_wait(input int n);
    repeat (n) @(posedge clk iff (strobe && agg_fs));
  endtask : frame_wait

  task automatic measure(input logic [2:0] pattern, input logic [1:0] mode);
    ctrl_pattern <= pattern;
    src_mode <= 2'h0;
    frame_wait(2);
    ones = 0;
    bits = 0;
    src_mode <= mode;
    count_on <= 1'b1;
    frame_wait(1);
    count_on <= 1'b0;
    src_mode <= 2'h0;
  endtask : measure

  // Source bits are judged once per aggregate bit, after the design has had time to update them.
  always @(posedge clk) begin
    cycles++;
    if (count_on && t_clk) begin
      bits++;
      if (t_data) ones++;
    end
    if (strobe && src_mode != 2'h0) begin
      exp_en = src_mode != 2'h1 && pos_off[1:0] == 2'h1 && !(pos_set == 2'h0 && pos_off < 8'h0c);
      check(out_en, exp_en);
      if (exp_en) check(out_data, src_mode == 2'h2 && !(pos_set == 2'h3 && pos_off == 8'h05));
    end
    // The timeout comes last, so nothing in this process runs after the run is closed.
    if (cycles == 100000) begin
      fail_count++;
      close_out();
    end
  end

  initial begin
    repeat (8) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    bus_rd(4'h0, rd);
    check(rd, 32'h0);
    bus_rd(4'h1, rd);
    check(rd, 32'h0);
    bus_wr(4'h4, 32'hffffffff);
    tsf <= 1'b1;
    wait_flag(1'b0, 1'b1);
    bus_rd(4'h4, rd);
    check(rd[1:0], 2'h2);
    check(t_data, 1'b1);
    tsf <= 1'b0;
    bus_wr(4'h0, 32'h2);
    wait_flag(1'b0, 1'b0);
    frame_wait(1);
    // A stalled receiver must see the head bit held, not lost.
    ready <= 1'b0;
    // The head is only meaningful once a bit stands in the buffer.
    do @(posedge clk); while (t_valid !== 1'b1);
    d0 = t_data;
    repeat (200) @(posedge clk);
    check({t_valid, t_data}, {1'b1, d0});
    ready <= 1'b1;
    measure(3'h7, 2'h1);
    check(ones, 0);
    check(bits > 150, 1);
    bus_wr(4'h0, 32'h3);
    measure(3'h2, 2'h2);
    check(ones > 0, 1);
    bus_rd(4'h8, rd);
    check(rd[15:0] != 16'h0, 1);
    trib_run <= 1'b1;
    measure(3'h3, 2'h3);
    check(ones, 0);
    tsf <= 1'b1;
    wait_flag(1'b1, 1'b1);
    bus_rd(4'h4, rd);
    check(rd[1:0], 2'h3);
    ones = 0;
    bits = 0;
    count_on <= 1'b1;
    repeat (600) @(posedge clk);
    count_on <= 1'b0;
    check(ones, bits);
    tsf <= 1'b0;
    wait_flag(1'b0, 1'b0);
    bus_wr(4'h0, 32'h0);
    wait_flag(1'b0, 1'b1);
    src_mode <= 2'h1;
    frame_wait(1);
    close_out();
  end
endmodule : tb

`default_nettype wire
